// ===== hw/fse_lock_mem.sv
// Per-sector persistent and dynamic lock bit storage with registered read.
`timescale 1ns/1ps
module fse_lock_mem #(
  parameter int DEPTH = 264,
  parameter int IDX_W = 9
) (
  input  wire logic             i_clk,     // System clock.
  input  wire logic             i_sys_rst, // Synchronous reset, active high.
  input  wire logic             i_wr_en,   // Write strobe.
  input  wire logic [IDX_W-1:0] i_wr_idx,  // Sector index to write.
  input  wire logic [1:0]       i_wr_data, // {persistent, dynamic} lock bits.
  input  wire logic             i_rd_en,   // Read strobe.
  input  wire logic [IDX_W-1:0] i_rd_idx,  // Sector index to read.
  output logic      [1:0]       o_rd_data  // Lock bits, one cycle after read.
);

  logic [1:0] mem_q [DEPTH];

  if (DEPTH > (1 << IDX_W)) begin : g_bad_depth
    $error("DEPTH does not fit IDX_W");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Reset unlocks everything; there is no nonvolatile cell behind this model.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 2'h0;
      end
    end else if (i_wr_en && (int'(i_wr_idx) < DEPTH)) begin
      mem_q[i_wr_idx] <= i_wr_data;
    end
  end

  // Registered read port; out-of-range indices read as unlocked.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 2'h0;
    end else if (i_rd_en) begin
      o_rd_data <= (int'(i_rd_idx) < DEPTH) ? mem_q[i_rd_idx] : 2'h0;
    end
  end

endmodule : fse_lock_mem

// ===== hw/fse_pkg.sv
// Shared constants for the sector erase command sequencer.
package fse_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] WRITE_ENABLE_CMD           = 8'h06;
  localparam logic [7:0] PAGE_WRITE_CMD             = 8'h02;
  localparam logic [7:0] PAGE_WRITE_WIDE_CMD        = 8'h12;
  localparam logic [7:0] PARAM_SECTOR_WIPE_CMD      = 8'h20;
  localparam logic [7:0] PARAM_SECTOR_WIPE_WIDE_CMD = 8'h21;
  localparam logic [7:0] BLOCK_WIPE_CMD             = 8'hd8;
  localparam logic [7:0] BLOCK_WIPE_WIDE_CMD        = 8'hdc;

  // ----------------------------------------------------------------
  // Register bit positions
  // ----------------------------------------------------------------
  localparam int CFG2_ADDR4_BIT     = 7;
  localparam int CFG2_QUAD_BIT      = 6;
  localparam int CFG3_UNIFORM_BIT   = 3;
  localparam int CFG3_PARAM_TOP_BIT = 2;
  localparam int CFG3_SECT256_BIT   = 1;
  localparam int STS_WIP_BIT        = 0;
  localparam int STS_WEL_BIT        = 1;
  localparam int STS_EERR_BIT       = 5;

  // ----------------------------------------------------------------
  // Frame lengths in bits and sector geometry as address bit counts
  // ----------------------------------------------------------------
  localparam logic [5:0] LEN_OPCODE = 6'h08;
  localparam logic [5:0] LEN_ADDR3  = 6'h20;
  localparam logic [5:0] LEN_ADDR4  = 6'h28;
  localparam logic [5:0] CNT_SAT    = 6'h3b;
  localparam int PARAM_LOG2         = 12;
  localparam int REGION_LOG2        = 15;
  localparam int UNIT_LOG2          = 16;
  localparam int BIG_LOG2           = 18;
  localparam int PARAM_COUNT        = 8;
  localparam logic [2:0] BP_MAX     = 3'h7;

  // ----------------------------------------------------------------
  // Timing: default phase times and their cycle counts at 200 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PRE_TIME_NS   = 10000;
  localparam int ERASE_TIME_NS = 50000;
  localparam int PRE_CYCLES_DEF   = (PRE_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {FSE_SZ_4K, FSE_SZ_64K, FSE_SZ_256K} fse_size_t;

endpackage : fse_pkg

// ===== hw/fse_seq.sv
// Serial command decoder and sector erase sequencer of the flash device.
//
// Summary of operation
// - Quad mode moves the instruction four bits per clock, two clocks per byte.
// - Page write address top bit is A23 or A31 by address length for 02h, A31 for 12h.
// - Parameter sectors sit at bottom or top, or are absent in uniform mode.
// - Parameter wipe opcodes are ignored when uniform-only bit is set.
// - Parameter wipe erases one whole 4 KB parameter sector.
// - Erase is accepted only with the write enable latch set.
// - 20h takes three or four address bytes by address length; 21h takes four.
// - D8h takes three or four address bytes by address length; DCh takes four.
// - Select rising at any other bit count cancels the erase.
// - Select rising after a valid erase starts pre-program then erase.
// - Busy flag reads one during the erase cycle, zero afterwards.
// - Parameter wipe of a protected sector is skipped and sets the error flag.
// - Parameter wipe outside parameter sectors is skipped without error.
// - Block wipe erases the sector, or skips and flags error when protected.
// - Sector size bit selects 64 KB or 256 KB block wipe.
// - With parameter sectors on, they overlay the top or bottom 32 KB.
// - Block wipe over an overlay leaves the parameter sectors untouched.
// - Uniform mode block wipe always covers a whole block.
// - Each physical sector keeps one persistent and one dynamic lock bit.
// - A 256 KB wipe with any locked 64 KB sector is skipped and flagged.
// - Busy is bit 0 of volatile status one.
// - Config two bit 7 selects four-byte address, bit 6 quad mode.
`timescale 1ns/1ps
module fse_seq
  import fse_pkg::*;
#(
  parameter int          ADDR_W       = 24,
  parameter int unsigned PRE_CYCLES   = PRE_CYCLES_DEF,
  parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DEF,
  localparam int         IDX_W        = ADDR_W - UNIT_LOG2 + 1
) (
  input  wire logic              i_clk,                 // System clock, 200 MHz.
  input  wire logic              i_sys_rst,             // Synchronous reset, high.
  input  wire logic              i_sck,                 // Serial clock pin.
  input  wire logic              i_cs_n,                // Chip select pin, low.
  input  wire logic [3:0]        i_quad_data_lines,     // Data pins, bit 0 = SI.
  input  wire logic [7:0]        i_volatile_config_two, // Address and quad mode.
  input  wire logic [7:0]        i_volatile_config_three, // Sector layout.
  input  wire logic [2:0]        i_bp_bits,             // Block protection level.
  input  wire logic              i_status_clear,        // Clears the error flag.
  input  wire logic              i_lock_wr,             // Lock bit write strobe.
  input  wire logic [IDX_W-1:0]  i_lock_idx,            // Physical sector index.
  input  wire logic              i_lock_ppb,            // Persistent lock bit.
  input  wire logic              i_lock_dyb,            // Dynamic lock bit.
  output logic      [7:0]        o_volatile_status_one, // Busy, latch, error.
  output logic                   o_erase_start,         // Erase cycle begins.
  output logic      [ADDR_W-1:0] o_erase_addr,          // Aligned erase base.
  output logic      [1:0]        o_erase_size,          // Erase size code.
  output logic                   o_erase_keep_param,    // Spare overlaid sectors.
  output logic                   o_erase_phase,         // 0 pre-program, 1 erase.
  output logic                   o_prog_addr_valid,     // Page write address ready.
  output logic      [31:0]       o_prog_addr            // Page write start address.
);

  if (ADDR_W < BIG_LOG2 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 18 and 32");
  end
  if (PRE_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_bad_cycles
    $error("Phase cycle counts must be at least one");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_JUDGE, ST_PRE, ST_ERASE} fse_state_t;

  localparam logic [IDX_W-1:0] NSECT = IDX_W'(1) << (ADDR_W - UNIT_LOG2);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic       sck_p_q;
  logic       cs_p_q;

  // Clock, select and data cross together so a sampled nibble lines up
  // with the clock edge that qualified it; the serial clock must stay
  // high and low for at least three system clocks each.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_q <= 6'h10;
      sync2_q <= 6'h10;
      sck_p_q <= 1'b0;
      cs_p_q  <= 1'b1;
    end else begin
      sync1_q <= {i_sck, i_cs_n, i_quad_data_lines};
      sync2_q <= sync1_q;
      sck_p_q <= sync2_q[5];
      cs_p_q  <= sync2_q[4];
    end
  end

  logic       cs_s;
  logic [3:0] io_s;
  logic       sck_rise;
  logic       cs_rise;

  assign cs_s     = sync2_q[4];
  assign io_s     = sync2_q[3:0];
  assign sck_rise = sync2_q[5] && !sck_p_q && !cs_s;
  assign cs_rise  = cs_s && !cs_p_q;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  logic cfg_addr4;
  logic cfg_quad;
  logic cfg_uniform;
  logic cfg_top;
  logic cfg_big;

  assign cfg_addr4   = i_volatile_config_two[CFG2_ADDR4_BIT];
  assign cfg_quad    = i_volatile_config_two[CFG2_QUAD_BIT];
  assign cfg_uniform = i_volatile_config_three[CFG3_UNIFORM_BIT];
  assign cfg_top     = i_volatile_config_three[CFG3_PARAM_TOP_BIT];
  assign cfg_big     = i_volatile_config_three[CFG3_SECT256_BIT];

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  logic [5:0]  cnt_q;
  logic [31:0] sh_q;
  logic [7:0]  op_q;
  logic [31:0] addr_q;
  logic [5:0]  cnt_nxt;
  logic [31:0] sh_nxt;
  logic        op_wide;
  logic        op_narrow;
  logic [5:0]  len_w;

  // In quad mode every phase is a nibble per clock, so one byte takes
  // two serial clocks; otherwise one bit per clock on the SI line.
  assign sh_nxt  = cfg_quad ? {sh_q[27:0], io_s} : {sh_q[30:0], io_s[0]};
  assign cnt_nxt = (cnt_q > CNT_SAT) ? cnt_q :
                   (cnt_q + (cfg_quad ? 6'h04 : 6'h01));

  assign op_wide   = (op_q == PARAM_SECTOR_WIPE_WIDE_CMD) ||
                     (op_q == BLOCK_WIPE_WIDE_CMD) || (op_q == PAGE_WRITE_WIDE_CMD);
  assign op_narrow = (op_q == PARAM_SECTOR_WIPE_CMD) ||
                     (op_q == BLOCK_WIPE_CMD) || (op_q == PAGE_WRITE_CMD);
  // Wide opcodes always carry four address bytes, narrow ones follow
  // the address length bit.
  assign len_w = (op_wide || (op_narrow && cfg_addr4)) ? LEN_ADDR4 : LEN_ADDR3;

  // The bit counter restarts whenever select is high; it saturates so a
  // long frame can never wrap back onto a valid length.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || cs_s) begin
      cnt_q <= 6'h00;
    end else if (sck_rise) begin
      cnt_q <= cnt_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sh_q <= 32'h0000_0000;
    end else if (sck_rise) begin
      sh_q <= sh_nxt;
    end
  end

  // Opcode is caught at the eighth bit, the address at the frame length
  // that the opcode implies.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      op_q   <= 8'h00;
      addr_q <= 32'h0000_0000;
    end else if (sck_rise) begin
      if (cnt_nxt == LEN_OPCODE) begin
        op_q <= sh_nxt[7:0];
      end
      if (cnt_q >= LEN_OPCODE && cnt_nxt == len_w) begin
        addr_q <= (len_w == LEN_ADDR4) ? sh_nxt : {8'h00, sh_nxt[23:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode at select rising
  // ----------------------------------------------------------------
  fse_state_t        state_q;
  fse_state_t        state_d;
  logic              wel_q;
  logic              is_param;
  logic              is_erase;
  logic              er_frame;
  logic              ignore_param;
  logic              in_region;
  logic              go;
  logic [IDX_W-1:0]  unit_first;
  logic [IDX_W-1:0]  unit_last;
  logic [IDX_W-1:0]  prot_units;
  logic [ADDR_W-1:0] tgt;

  assign is_param = (op_q == PARAM_SECTOR_WIPE_CMD) || (op_q == PARAM_SECTOR_WIPE_WIDE_CMD);
  assign is_erase = is_param || (op_q == BLOCK_WIPE_CMD) || (op_q == BLOCK_WIPE_WIDE_CMD);
  assign tgt      = addr_q[ADDR_W-1:0];

  // Frames with the latch clear, or arriving while busy, never get here.
  assign er_frame = cs_rise && (cnt_q >= LEN_OPCODE) && is_erase &&
                    wel_q && (state_q == ST_IDLE);
  assign ignore_param = is_param && cfg_uniform;
  // Parameter sectors fill the lowest or highest 32 KB region.
  assign in_region = cfg_top ? (&tgt[ADDR_W-1:REGION_LOG2])
                             : (tgt[ADDR_W-1:REGION_LOG2] == '0);
  // Select must rise exactly at the last address bit.
  assign go = er_frame && (cnt_q == len_w) && !ignore_param &&
              (!is_param || in_region);

  // Range of 64 KB units touched by a block wipe; 256 KB spans four.
  assign unit_first = IDX_W'(tgt[ADDR_W-1:UNIT_LOG2]) &
                      ((cfg_big && !is_param) ? ~IDX_W'(3) : ~IDX_W'(0));
  assign unit_last  = unit_first + ((cfg_big && !is_param) ? IDX_W'(3) : IDX_W'(0));
  // Block protection covers a top fraction of the array, all at level 7.
  assign prot_units = (i_bp_bits == 3'h0) ? '0 : (NSECT >> (BP_MAX - i_bp_bits));

  // ----------------------------------------------------------------
  // Erase job registers
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] rd_first_q;
  logic [1:0]       rd_last_q;
  logic [1:0]       k_q;
  logic             bp_hit_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_erase_addr       <= '0;
      o_erase_size       <= FSE_SZ_64K;
      o_erase_keep_param <= 1'b0;
      rd_first_q         <= '0;
      rd_last_q          <= 2'h0;
      bp_hit_q           <= 1'b0;
    end else if (go) begin
      bp_hit_q <= (unit_last >= NSECT - prot_units);
      if (is_param) begin
        o_erase_addr       <= {tgt[ADDR_W-1:PARAM_LOG2], PARAM_LOG2'(0)};
        o_erase_size       <= FSE_SZ_4K;
        o_erase_keep_param <= 1'b0;
        rd_first_q         <= NSECT + IDX_W'(tgt[REGION_LOG2-1:PARAM_LOG2]);
        rd_last_q          <= 2'h0;
      end else begin
        o_erase_addr <= {unit_first[IDX_W-2:0], UNIT_LOG2'(0)};
        o_erase_size <= cfg_big ? FSE_SZ_256K : FSE_SZ_64K;
        // Overlaid parameter sectors survive a block wipe; uniform mode
        // has none, so the whole block goes.
        o_erase_keep_param <= !cfg_uniform &&
                              (cfg_top ? (unit_last == NSECT - IDX_W'(1))
                                       : (unit_first == '0));
        rd_first_q <= unit_first;
        rd_last_q  <= cfg_big ? 2'h3 : 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock bit lookup
  // ----------------------------------------------------------------
  logic       rd_vld_q;
  logic       hit_q;
  logic [1:0] lock_rd;

  fse_lock_mem #(
    .DEPTH (int'(NSECT) + PARAM_COUNT),
    .IDX_W (IDX_W)
  ) u_lock_mem (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr_en   (i_lock_wr),
    .i_wr_idx  (i_lock_idx),
    .i_wr_data ({i_lock_ppb, i_lock_dyb}),
    .i_rd_en   (state_q == ST_CHECK),
    .i_rd_idx  (rd_first_q + IDX_W'(k_q)),
    .o_rd_data (lock_rd)
  );

  // Any locked sector in the range poisons the whole request.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || go) begin
      hit_q    <= 1'b0;
      rd_vld_q <= 1'b0;
      k_q      <= 2'h0;
    end else begin
      rd_vld_q <= (state_q == ST_CHECK);
      if (state_q == ST_CHECK) begin
        k_q <= k_q + 2'h1;
      end
      if (rd_vld_q && (|lock_rd)) begin
        hit_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [31:0] tmr_q;
  logic        judge_now;
  logic        refuse;

  assign judge_now = (state_q == ST_JUDGE) && !rd_vld_q;
  assign refuse    = judge_now && (hit_q || bp_hit_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (go) state_d = ST_CHECK;
      ST_CHECK: if (k_q == rd_last_q) state_d = ST_JUDGE;
      ST_JUDGE: if (judge_now) state_d = refuse ? ST_IDLE : ST_PRE;
      ST_PRE:   if (tmr_q == 32'h0) state_d = ST_ERASE;
      ST_ERASE: if (tmr_q == 32'h0) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Phase timer: pre-program first, then the erase proper.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tmr_q <= 32'h0;
    end else if (state_q != ST_PRE && state_d == ST_PRE) begin
      tmr_q <= 32'(PRE_CYCLES - 1);
    end else if (state_q == ST_PRE && state_d == ST_ERASE) begin
      tmr_q <= 32'(ERASE_CYCLES - 1);
    end else if (tmr_q != 32'h0) begin
      tmr_q <= tmr_q - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  logic busy_q;
  logic err_q;
  logic wel_clr;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_q        <= 1'b0;
      o_erase_phase <= 1'b0;
      o_erase_start <= 1'b0;
    end else begin
      busy_q        <= (state_d != ST_IDLE);
      o_erase_phase <= (state_d == ST_ERASE);
      o_erase_start <= judge_now && !refuse;
    end
  end

  // A refused or finished erase leaves the latch clear; ignored parameter
  // wipes in uniform mode keep it.
  assign wel_clr = (er_frame && !ignore_param && !go) || refuse ||
                   (state_q == ST_ERASE && state_d == ST_IDLE);

  // Write enable is honoured only as a complete one-byte frame; a set in
  // the same cycle as a clear wins.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wel_q <= 1'b0;
    end else if (cs_rise && cnt_q == LEN_OPCODE && op_q == WRITE_ENABLE_CMD) begin
      wel_q <= 1'b1;
    end else if (wel_clr) begin
      wel_q <= 1'b0;
    end
  end

  // Protection refusals raise the error flag; a refusal beats a clear.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      err_q <= 1'b0;
    end else if (refuse) begin
      err_q <= 1'b1;
    end else if (i_status_clear) begin
      err_q <= 1'b0;
    end
  end

  always_comb begin
    o_volatile_status_one               = 8'h00;
    o_volatile_status_one[STS_WIP_BIT]  = busy_q;
    o_volatile_status_one[STS_WEL_BIT]  = wel_q;
    o_volatile_status_one[STS_EERR_BIT] = err_q;
  end

  // ----------------------------------------------------------------
  // Page write address hand-off
  // ----------------------------------------------------------------
  // The program engine sits elsewhere; this only reports where a page
  // write starts, using A23 or A31 as the top address bit.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prog_addr_valid <= 1'b0;
      o_prog_addr       <= 32'h0000_0000;
    end else begin
      o_prog_addr_valid <= sck_rise && (cnt_q >= LEN_OPCODE) && (cnt_nxt == len_w) &&
                           wel_q && (state_q == ST_IDLE) &&
                           (op_q == PAGE_WRITE_CMD || op_q == PAGE_WRITE_WIDE_CMD);
      if (sck_rise && (cnt_q >= LEN_OPCODE) && (cnt_nxt == len_w)) begin
        o_prog_addr <= (len_w == LEN_ADDR4) ? sh_nxt : {8'h00, sh_nxt[23:0]};
      end
    end
  end

endmodule : fse_seq

// ===== verification/flash_sector_erase_commands_tb_top.sv
// Self-checking bench for the sector erase sequencer.
`timescale 1ns/1ps
module flash_sector_erase_commands_tb_top import fse_pkg::*;;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, clr = 1'b0, lwr = 1'b0;
  logic        sck, cs_n, start, pvalid, keep;
  logic [3:0]  dat;
  logic [7:0]  cfg2 = 8'h00, cfg3 = 8'h08, sts;
  logic [23:0] eaddr, r = 24'h00001e;
  logic [31:0] paddr, prog_q[$];
  logic [26:0] exp_q[$];
  logic [1:0]  esize;
  logic [2:0]  bp = 3'h0;
  int          fails = 0, check_count = 0;
  initial forever #2.5 i_clk = ~i_clk;
  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction : lfsr
  // Lock index and value are fixed; every lock write locks 64 KB unit 2.
  fse_seq #(.PRE_CYCLES(4), .ERASE_CYCLES(8)) fse_seq_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sck(sck), .i_cs_n(cs_n), .i_quad_data_lines(dat),
    .i_volatile_config_two(cfg2), .i_volatile_config_three(cfg3), .i_bp_bits(bp),
    .i_status_clear(clr), .i_lock_wr(lwr), .i_lock_idx(9'h002), .i_lock_ppb(1'b0),
    .i_lock_dyb(1'b1), .o_volatile_status_one(sts), .o_erase_start(start), .o_erase_addr(eaddr),
    .o_erase_size(esize), .o_erase_keep_param(keep), .o_erase_phase(), .o_prog_addr_valid(pvalid),
    .o_prog_addr(paddr));
  fse_host_model fse_host_model_inst (.i_clk(i_clk), .o_sck(sck), .o_cs_n(cs_n), .o_data(dat));
  task automatic chk(input logic ok, input string what);
    check_count++;
    fails += int'(ok !== 1'b1);
    if (ok !== 1'b1) $display("MISMATCH %0t %s", $time, what);
  endtask : chk
  // Results are judged at the falling edge, once settled, against the oldest note.
  always @(negedge i_clk) begin
    if (start === 1'b1) chk(exp_q.size() != 0 &&
      {keep, esize, eaddr} === exp_q.pop_front(), "erase");
    if (pvalid === 1'b1) chk(prog_q.size() != 0 && paddr === prog_q.pop_front(), "page");
  end
  task automatic final_report();
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic run(input logic [7:0] c2, c3, op, input int ab, cut, input logic [31:0] adr,
                     input logic en, go, input logic [2:0] sz, input logic write_enable_latch_bit, err);
    int k;
    @(negedge i_clk);
    cfg2 = c2;
    cfg3 = c3;
    if (en) fse_host_model_inst.frame(48'(WRITE_ENABLE_CMD), 8, c2[6]);
    if (go) exp_q.push_back({sz, adr[23:0] & ~(sz[1] ? 24'h03ffff : sz[0] ? 24'h00ffff : 24'h000fff)});
    fse_host_model_inst.frame((48'(op) << ab | 48'(adr)) >> cut, 8 + ab - cut, c2[6]);
    for (k = 0; k < 9 || (k < 99 && sts[0] !== 1'b0); k++) @(negedge i_clk);
    chk(k < 99 && sts[1] === write_enable_latch_bit && sts[5] === err, "status");
    if (k == 99) final_report();
    clr = 1'b1;
    r = lfsr(r);
    @(negedge i_clk);
    clr = 1'b0;
  endtask : run
  initial begin
    repeat (8) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    run(8'h00,8'h08,BLOCK_WIPE_CMD,24,0,{8'h00,r},0,0,3'h1,0,0);
    run(8'h00,8'h08,BLOCK_WIPE_CMD,24,0,{8'h00,r},1,1,3'h1,0,0);
    run(8'h80,8'h08,BLOCK_WIPE_CMD,32,0,{r[7:0],r},1,1,3'h1,0,0);
    run(8'h00,8'h0a,BLOCK_WIPE_WIDE_CMD,32,0,{r[7:0],r},1,1,3'h2,0,0);
    run(8'h00,8'h00,PARAM_SECTOR_WIPE_CMD,24,0,{17'h0,r[14:0]},1,1,3'h0,0,0);
    run(8'h40,8'h04,PARAM_SECTOR_WIPE_WIDE_CMD,32,0,{r[7:0],9'h1ff,r[14:0]},1,1,3'h0,0,0);
    run(8'h00,8'h08,PARAM_SECTOR_WIPE_CMD,24,0,{17'h0,r[14:0]},1,0,3'h0,1,0);
    run(8'h00,8'h00,PARAM_SECTOR_WIPE_CMD,24,1,{17'h0,r[14:0]},1,0,3'h0,0,0);
    run(8'h00,8'h00,PARAM_SECTOR_WIPE_CMD,24,0,{16'h0001,r[15:0]},1,0,3'h0,0,0);
    bp = 3'h1;
    run(8'h00,8'h04,PARAM_SECTOR_WIPE_CMD,24,0,{8'h00,9'h1ff,r[14:0]},1,0,3'h0,0,1);
    run(8'h00,8'h00,BLOCK_WIPE_CMD,24,0,{16'h0000,r[15:0]},1,1,3'h5,0,0);
    lwr = 1'b1;
    @(negedge i_clk);
    lwr = 1'b0;
    run(8'h00,8'h08,BLOCK_WIPE_CMD,24,0,{16'h0002,r[15:0]},1,0,3'h1,0,1);
    run(8'h00,8'h0a,BLOCK_WIPE_WIDE_CMD,32,0,{14'h0,r[17:0]},1,0,3'h2,0,1);
    fse_host_model_inst.frame(48'(WRITE_ENABLE_CMD), 8, 1'b0);
    prog_q.push_back({r, 8'h00});
    fse_host_model_inst.frame({PAGE_WRITE_WIDE_CMD, r, 8'h00, 8'ha5}, 48, 1'b0);
    prog_q.push_back({8'h00, r});
    fse_host_model_inst.frame(48'({PAGE_WRITE_CMD, r, 8'h5a}), 40, 1'b0);
    repeat (20) @(negedge i_clk);
    chk(exp_q.size() == 0 && prog_q.size() == 0, "missing result");
    final_report();
  end
endmodule : flash_sector_erase_commands_tb_top

// ===== verification/fse_host_model.sv
// Behavioural SPI host that frames commands onto the sequencer pins.
`timescale 1ns/1ps
module fse_host_model (
  input  wire logic  i_clk,         // System clock.
  output logic       o_sck  = 1'b0, // Serial clock, still between frames.
  output logic       o_cs_n = 1'b1, // Chip select, active low.
  output logic [3:0] o_data = 4'h0  // Data lines, MSB first.
);
  // Four system clocks per serial half period leave margin over the synchroniser minimum.
  task automatic frame(input logic [47:0] bits, input int n, input logic quad);
    @(negedge i_clk) o_cs_n = 1'b0;
    for (int i = n - (quad ? 4 : 1); i >= 0; i -= quad ? 4 : 1) begin
      o_data = quad ? bits[i+:4] : {3'h0, bits[i]};
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (2) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_data = ~o_data; // A released line must not keep showing its last value.
    repeat (4) @(negedge i_clk);
  endtask : frame
endmodule : fse_host_model

// ===== verification/fse_seq_sva.sv
// Port-level assertion checker for the sector erase sequencer.
`timescale 1ns/1ps
module fse_seq_sva #(
  parameter int ADDR_W       = 24, // Address width.
  parameter int PRE_CYCLES   = 4,  // Pre-program length.
  parameter int ERASE_CYCLES = 8   // Erase length.
) (
  input wire logic              i_clk,                 // Clock.
  input wire logic              i_sys_rst,             // Reset.
  input wire logic [7:0]        o_volatile_status_one, // Status.
  input wire logic              o_erase_start,         // Start pulse.
  input wire logic [ADDR_W-1:0] o_erase_addr,          // Erase base.
  input wire logic [1:0]        o_erase_size,          // Size code.
  input wire logic              o_erase_phase,         // Phase.
  input wire logic              o_prog_addr_valid      // Page address pulse.
);
  localparam int PH_LO = PRE_CYCLES - 1, PH_HI = PRE_CYCLES + 1;
  localparam int BUSY_HI = PRE_CYCLES + ERASE_CYCLES;
  // The fall bound on busy catches a phase counter that never expires.
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  chk_busy_window: assert property (o_erase_start |-> o_volatile_status_one[0] [*8]
    ##[1:BUSY_HI] !o_volatile_status_one[0]) else $error("busy window wrong");
  chk_start_single: assert property (o_erase_start |=> !o_erase_start) else $error("long start");
  chk_phase_order: assert property (o_erase_start |-> !o_erase_phase ##[PH_LO:PH_HI] o_erase_phase)
    else $error("phase order wrong");
  chk_latch_clear: assert property ($fell(o_volatile_status_one[0]) |-> !o_volatile_status_one[1])
    else $error("latch kept after busy");
  chk_align_param: assert property (o_erase_start && o_erase_size == 2'h0
    |-> o_erase_addr[11:0] == 12'h000) else $error("4K base misaligned");
  chk_align_block: assert property (o_erase_start && o_erase_size == 2'h1
    |-> o_erase_addr[15:0] == 16'h0000) else $error("64K base misaligned");
  chk_addr_hold: assert property (o_volatile_status_one[0] && $past(o_volatile_status_one[0])
    |-> $stable(o_erase_addr)) else $error("erase base moved while busy");
  chk_prog_ready: assert property (o_prog_addr_valid |-> o_volatile_status_one[1:0] == 2'h2)
    else $error("page address outside idle latch");
  cover property (o_erase_start && o_erase_size == 2'h0);
  cover property (o_erase_start && o_erase_size == 2'h2);
  cover property ($rose(o_volatile_status_one[5]));
endmodule : fse_seq_sva
bind fse_seq fse_seq_sva #(.ADDR_W(ADDR_W), .PRE_CYCLES(PRE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES))
  fse_seq_sva_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_volatile_status_one(o_volatile_status_one),
  .o_erase_start(o_erase_start), .o_erase_addr(o_erase_addr), .o_erase_size(o_erase_size),
  .o_erase_phase(o_erase_phase), .o_prog_addr_valid(o_prog_addr_valid));
